// ---- fault_setup_pkg.sv ----
// Purpose: Shared constants for the laser fault configuration logic.
// Assumes: 100 MHz system clock; register reached by its command code.
// Notes:   Field positions and reset values of the fault_setup register.
package fault_setup_pkg;

    // Register access
    localparam logic [7:0]  FAULT_SETUP_CODE  = 8'h13;
    localparam logic [15:0] FAULT_SETUP_RESET = 16'h04E7;
    localparam logic [15:0] FAULT_SETUP_WMASK = 16'h0FFF; // Bits 15:12 reserved
    localparam logic [15:0] READ_ZERO         = 16'h0000;

    // Field positions inside fault_setup
    localparam int FS_REPEAT_LOCK = 11;
    localparam int FS_FAST_RESUME = 10;
    localparam int FS_DRIVE_HI    = 9;
    localparam int FS_DRIVE_LO    = 8;
    localparam int FS_SERVO_EN    = 7;
    localparam int FS_AUTO_OFF    = 6;
    localparam int FS_PIN_POL     = 5;
    localparam int FS_OVERRIDE    = 4;
    localparam int FS_FORCE       = 3;
    localparam int FS_OVERPWR_EN  = 2;
    localparam int FS_UNDERPWR_EN = 1;
    localparam int FS_OVERCUR_EN  = 0;

    // Fault pin drive modes
    localparam logic [1:0] DRIVE_OPEN_DRAIN = 2'h0;
    localparam logic [1:0] DRIVE_PULLUP_280 = 2'h1;
    localparam logic [1:0] DRIVE_PULLUP_425 = 2'h2;
    localparam logic [1:0] DRIVE_PUSH_PULL  = 2'h3;

    // Timing: lockout window counted in 1 ms ticks
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_TIME_NS  = 1_000_000;
    localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int LOCK_WINDOW_MS = 25;
    localparam logic [4:0] LOCK_LAST_TICK = 5'(LOCK_WINDOW_MS - 1);
    localparam logic [4:0] TICK_COUNT_ONE = 5'h01;

    // Current DAC width
    localparam int DAC_WIDTH = 10;

endpackage : fault_setup_pkg

// ---- ms_tick_divider.sv ----
// Purpose: Divides the system clock into a one-cycle enable pulse.
// Assumes: Single clock domain; restart aligns the first pulse.
// Notes:   First pulse comes CYCLES edges after a restart.
`timescale 1ns/1ps
module ms_tick_divider #(
    parameter int CYCLES = fault_setup_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    // Control
    input  wire logic i_restart,
    // Enable pulse
    output logic      o_tick
);

    typedef struct packed {
        logic [31:0] count;
        logic        tick;
    } div_state_t;

    localparam logic [31:0] LAST = 32'(CYCLES - 1);

    div_state_t div_reg;
    div_state_t div_next;

    // Count up through a period; restart lets the window begin on a clean period
    always_comb begin
        div_next      = div_reg;
        div_next.tick = 1'b0;
        if (i_restart) begin
            div_next.count = 32'h0000_0000;
        end else if (div_reg.count == LAST) begin
            div_next.count = 32'h0000_0000;
            div_next.tick  = 1'b1;
        end else begin
            div_next.count = div_reg.count + 32'h0000_0001;
        end
    end

    // State register
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign o_tick = div_reg.tick;

endmodule : ms_tick_divider

// ---- laser_fault_config_logic.sv ----
// Purpose: Fault configuration, lockout, servo retention and fault pin control.
// Assumes: Command-code register port after the serial decoder; inputs synchronous.
// Notes:   Outputs react one clock after their cause; a setup write acts one clock after it is stored.
//
// Contract
// - Lockout clear allows unlimited fault clear and re-enable attempts.
// - Lockout set: fault within 25ms of re-enable disables until power cycle.
// - Fast resume off: servo settings zeroed on disable, restart from zero.
// - Fast resume on: servo settings kept, loaded into DACs on re-enable.
// - Drive bits select open drain, 280uA pull-up, 425uA pull-up, push-pull.
// - Servo disabled: host writes alone set the bias and modulation DACs.
// - Servo enabled: servo updates both DACs, overwriting host writes.
// - Auto shutdown clear: laser stays driven after fault; host may disable.
// - Auto shutdown set: transmitter disabled as soon as a fault appears.
// - Polarity bit selects active-low (0) or active-high (1) fault pin.
// - Override clear: fault pin driven active whenever a fault occurs.
// - Override set: faults still latched but fault pin follows the force bit.
// - Force bit sets fault pin level, only while override is set.
// - Bit 2 gates overpower fault detection.
// - Bit 1 gates underpower fault detection.
// - Bit 0 gates overcurrent fault detection.
// - Transmitter enabled only with enable pin, software enable, no lockout, and no fault while auto shutdown is set.
// - Lockout: second fault within 25ms of re-enable sets second flag.
// - Lockout: no fault within 25ms of re-enable clears first flag.
`timescale 1ns/1ps
module laser_fault_config_logic #(
    parameter int TICK_CYCLES = fault_setup_pkg::TICK_CYCLES,
    parameter int DAC_WIDTH   = fault_setup_pkg::DAC_WIDTH
) (
    // Clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_reset_n,
    // Register command port
    input  wire logic                 i_reg_wr,
    input  wire logic                 i_reg_rd,
    input  wire logic [7:0]           i_cmd_code,
    input  wire logic [15:0]          i_wr_data,
    output logic      [15:0]          o_rd_data,
    output logic                      o_rd_valid,
    // Transmitter enables
    input  wire logic                 i_en_pin,
    input  wire logic                 i_soft_en,
    // Fault detectors
    input  wire logic                 i_over_power,
    input  wire logic                 i_under_power,
    input  wire logic                 i_over_current,
    input  wire logic                 i_fixed_fault,
    // Servo and host DAC values
    input  wire logic [DAC_WIDTH-1:0] i_servo_bias,
    input  wire logic [DAC_WIDTH-1:0] i_servo_mod,
    input  wire logic                 i_host_bias_wr,
    input  wire logic [DAC_WIDTH-1:0] i_host_bias,
    input  wire logic                 i_host_mod_wr,
    input  wire logic [DAC_WIDTH-1:0] i_host_mod,
    // Laser drive and servo seeding
    output logic                      o_tx_enabled,
    output logic [DAC_WIDTH-1:0]      o_bias_current_dac,
    output logic [DAC_WIDTH-1:0]      o_modulation_current_dac,
    output logic                      o_servo_seed,
    // Fault status
    output logic                      o_faulted,
    output logic                      o_faulted_once,
    output logic                      o_faulted_twice,
    // Fault pin
    output logic                      o_fault_pin_out,
    output logic                      o_fault_pin_oe,
    output logic                      o_pullup_280_en,
    output logic                      o_pullup_425_en
);

    typedef struct packed {
        logic [15:0]          setup;
        logic                 faulted;
        logic                 once;
        logic                 twice;
        logic                 tx_en;
        logic                 window_on;
        logic [4:0]           win_cnt;
        logic [DAC_WIDTH-1:0] keep_bias;
        logic [DAC_WIDTH-1:0] keep_mod;
        logic [DAC_WIDTH-1:0] dac_bias;
        logic [DAC_WIDTH-1:0] dac_mod;
        logic                 seed;
        logic                 pin_out;
        logic                 pin_oe;
        logic                 pu280;
        logic                 pu425;
        logic [15:0]          rd_data;
        logic                 rd_valid;
    } fault_state_t;

    // Default setup drives an inactive high-polarity open-drain pin: low, enabled
    localparam fault_state_t RESET_STATE = '{
        setup:   fault_setup_pkg::FAULT_SETUP_RESET,
        pin_oe:  1'b1,
        default: '0
    };

    fault_state_t state_reg;
    fault_state_t state_next;
    logic         fault_event;
    logic         enable_req;
    logic         tx_rise;
    logic         pin_active;
    logic         tick;

    // Pin level from activity, polarity and drive mode
    function automatic logic [3:0] pin_drive(input logic active, input logic pol,
                                             input logic [1:0] mode);
        logic level;
        level = active ? pol : ~pol;
        if (mode == fault_setup_pkg::DRIVE_PUSH_PULL) begin
            pin_drive = {level, 1'b1, 2'b00};
        end else begin
            // Open drain only pulls low; high comes from the pull-up or outside
            pin_drive = {1'b0, ~level,
                         mode == fault_setup_pkg::DRIVE_PULLUP_280,
                         mode == fault_setup_pkg::DRIVE_PULLUP_425};
        end
    endfunction : pin_drive

    // Window timebase, realigned when a lockout window opens
    ms_tick_divider #(
        .CYCLES    (TICK_CYCLES)
    ) u_tick (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_restart (tx_rise && state_reg.once),
        .o_tick    (tick)
    );

    // Next-state logic for the whole block
    always_comb begin
        state_next          = state_reg;
        state_next.rd_valid = 1'b0;
        state_next.seed     = 1'b0;

        // Register port; reserved bits never store
        if (i_reg_wr && i_cmd_code == fault_setup_pkg::FAULT_SETUP_CODE) begin
            state_next.setup = i_wr_data & fault_setup_pkg::FAULT_SETUP_WMASK;
        end
        if (i_reg_rd) begin
            state_next.rd_valid = 1'b1;
            state_next.rd_data  = (i_cmd_code == fault_setup_pkg::FAULT_SETUP_CODE) ?
                                  state_reg.setup : fault_setup_pkg::READ_ZERO;
        end

        // Detector gating by the enable bits
        fault_event = (i_over_power   && state_reg.setup[fault_setup_pkg::FS_OVERPWR_EN])
                    | (i_under_power  && state_reg.setup[fault_setup_pkg::FS_UNDERPWR_EN])
                    | (i_over_current && state_reg.setup[fault_setup_pkg::FS_OVERCUR_EN])
                    | i_fixed_fault;
        enable_req  = i_en_pin && i_soft_en;

        // Faulted latch: host clears it by dropping an enable; a new fault wins
        if (fault_event) begin
            state_next.faulted = 1'b1;
        end else if (!enable_req) begin
            state_next.faulted = 1'b0;
        end

        // Repeat lockout bookkeeping
        if (!state_reg.setup[fault_setup_pkg::FS_REPEAT_LOCK]) begin
            state_next.once      = 1'b0;
            state_next.window_on = 1'b0;
        end else begin
            if (state_reg.window_on) begin
                if (fault_event) begin
                    state_next.twice     = 1'b1;
                    state_next.window_on = 1'b0;
                end else if (tick && state_reg.win_cnt == fault_setup_pkg::LOCK_LAST_TICK) begin
                    state_next.once      = 1'b0;
                    state_next.window_on = 1'b0;
                end else if (tick) begin
                    state_next.win_cnt = state_reg.win_cnt + fault_setup_pkg::TICK_COUNT_ONE;
                end
            end
            // Placed last so a new first fault beats the quiet-window clear
            if (state_reg.faulted && !enable_req) begin
                state_next.once = 1'b1;
            end
        end

        // Transmitter enable; second fault locks it off until reset
        state_next.tx_en = enable_req && !state_next.twice
                        && !(state_next.faulted
                             && state_reg.setup[fault_setup_pkg::FS_AUTO_OFF]);
        tx_rise = state_next.tx_en && !state_reg.tx_en;
        if (tx_rise && state_reg.once && state_reg.setup[fault_setup_pkg::FS_REPEAT_LOCK]) begin
            state_next.window_on = 1'b1;
            state_next.win_cnt   = '0;
        end

        // DAC ownership and servo retention
        if (state_reg.setup[fault_setup_pkg::FS_SERVO_EN]) begin
            if (tx_rise) begin
                state_next.dac_bias = state_reg.keep_bias;
                state_next.dac_mod  = state_reg.keep_mod;
                state_next.seed     = 1'b1;
            end else if (state_reg.tx_en && state_next.tx_en) begin
                state_next.dac_bias  = i_servo_bias;
                state_next.dac_mod   = i_servo_mod;
                state_next.keep_bias = i_servo_bias;
                state_next.keep_mod  = i_servo_mod;
            end else if (!state_next.tx_en
                         && !state_reg.setup[fault_setup_pkg::FS_FAST_RESUME]) begin
                state_next.keep_bias = '0;
                state_next.keep_mod  = '0;
                state_next.dac_bias  = '0;
                state_next.dac_mod   = '0;
            end
        end else begin
            // Servo off: host writes own the DACs
            if (i_host_bias_wr) begin
                state_next.dac_bias = i_host_bias;
            end
            if (i_host_mod_wr) begin
                state_next.dac_mod = i_host_mod;
            end
        end

        // Fault pin: override replaces the latch with the force bit
        pin_active = state_reg.setup[fault_setup_pkg::FS_OVERRIDE] ?
                     state_reg.setup[fault_setup_pkg::FS_FORCE] :
                     state_next.faulted;
        {state_next.pin_out, state_next.pin_oe, state_next.pu280, state_next.pu425} =
            pin_drive(pin_active, state_reg.setup[fault_setup_pkg::FS_PIN_POL],
                      state_reg.setup[fault_setup_pkg::FS_DRIVE_HI:
                                      fault_setup_pkg::FS_DRIVE_LO]);
    end

    // State register; defaults loaded on reset
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= RESET_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    assign o_rd_data                = state_reg.rd_data;
    assign o_rd_valid               = state_reg.rd_valid;
    assign o_tx_enabled             = state_reg.tx_en;
    assign o_bias_current_dac       = state_reg.dac_bias;
    assign o_modulation_current_dac = state_reg.dac_mod;
    assign o_servo_seed             = state_reg.seed;
    assign o_faulted                = state_reg.faulted;
    assign o_faulted_once           = state_reg.once;
    assign o_faulted_twice          = state_reg.twice;
    assign o_fault_pin_out          = state_reg.pin_out;
    assign o_fault_pin_oe           = state_reg.pin_oe;
    assign o_pullup_280_en          = state_reg.pu280;
    assign o_pullup_425_en          = state_reg.pu425;

    // Helpers: wire level seen at the pin and whether it reads as active
    logic pin_level;
    logic pin_is_active;
    assign pin_level     = state_reg.pin_oe ? state_reg.pin_out : 1'b1;
    assign pin_is_active = (pin_level == state_reg.setup[fault_setup_pkg::FS_PIN_POL]);

    a_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        state_reg.rd_valid |-> state_reg.rd_data[15:12] == 4'h0)
        else $error("Reserved fault setup bits read nonzero");

    a_host_owns_dac: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (!state_reg.setup[fault_setup_pkg::FS_SERVO_EN] && i_host_bias_wr && !i_reg_wr)
        |=> state_reg.dac_bias == $past(i_host_bias))
        else $error("Host bias write lost with servo disabled");

    a_servo_owns_dac: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_reg.setup[fault_setup_pkg::FS_SERVO_EN] && state_reg.tx_en && !i_reg_wr)
        ##1 state_reg.tx_en |-> state_reg.dac_mod == $past(i_servo_mod))
        else $error("Modulation DAC not following servo");

    a_auto_shutdown: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_reg.setup[fault_setup_pkg::FS_AUTO_OFF] && fault_event && !i_reg_wr)
        |=> !state_reg.tx_en && state_reg.faulted)
        else $error("Transmitter still on after fault with auto shutdown");

    a_keeps_driving: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (!state_reg.setup[fault_setup_pkg::FS_AUTO_OFF] && !state_reg.twice
         && !state_reg.setup[fault_setup_pkg::FS_REPEAT_LOCK] && enable_req && !i_reg_wr)
        |=> state_reg.tx_en)
        else $error("Transmitter dropped without auto shutdown");

    a_fault_drives_pin: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (!state_reg.setup[fault_setup_pkg::FS_OVERRIDE] && fault_event && !i_reg_wr)
        |=> pin_is_active)
        else $error("Fault pin not active on fault");

    a_override_forces: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_reg.setup[fault_setup_pkg::FS_OVERRIDE] && !i_reg_wr)
        |=> pin_is_active == $past(state_reg.setup[fault_setup_pkg::FS_FORCE]))
        else $error("Fault pin not following force bit under override");

    a_push_pull: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_reg.setup[fault_setup_pkg::FS_DRIVE_HI:fault_setup_pkg::FS_DRIVE_LO]
         == fault_setup_pkg::DRIVE_PUSH_PULL && !i_reg_wr)
        |=> state_reg.pin_oe && !state_reg.pu280 && !state_reg.pu425)
        else $error("Push-pull mode not driving");

    a_overpower_gate: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (!state_reg.setup[fault_setup_pkg::FS_OVERPWR_EN] && !state_reg.faulted && !i_reg_wr
         && !i_under_power && !i_over_current && !i_fixed_fault)
        |=> !state_reg.faulted)
        else $error("Disabled overpower detection raised a fault");

    a_lockout_holds: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        state_reg.twice |-> !state_reg.tx_en ##1 state_reg.twice)
        else $error("Transmitter on after second fault");

    a_second_fault: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_reg.window_on && fault_event && !i_reg_wr
         && state_reg.setup[fault_setup_pkg::FS_REPEAT_LOCK])
        |=> state_reg.twice)
        else $error("Second fault in window not flagged");

    a_window_clears: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_reg.window_on && tick && !fault_event && !i_reg_wr
         && state_reg.win_cnt == fault_setup_pkg::LOCK_LAST_TICK
         && state_reg.setup[fault_setup_pkg::FS_REPEAT_LOCK])
        |=> !state_reg.once && !state_reg.window_on)
        else $error("First fault flag not cleared after quiet window");

    a_zero_on_disable: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_reg.setup[fault_setup_pkg::FS_SERVO_EN] && state_reg.tx_en && !enable_req
         && !state_reg.setup[fault_setup_pkg::FS_FAST_RESUME] && !i_reg_wr)
        |=> state_reg.keep_bias == '0 && state_reg.dac_bias == '0)
        else $error("Servo settings kept with fast resume off");

endmodule : laser_fault_config_logic

// ---- host_model.sv ----
// Purpose: Host side of the register port, the enables and the DAC writes.
// Assumes: One access at a time; signals change just after a rising edge.
// Notes:   Tasks are called by tb_top.
`timescale 1ns/1ps
module host_model (
    // Clock
    input  wire logic        i_sys_clk,
    // Register port
    output logic             o_reg_wr,
    output logic             o_reg_rd,
    output logic [7:0]       o_cmd_code,
    output logic [15:0]      o_wr_data,
    input  wire logic [15:0] i_rd_data,
    input  wire logic        i_rd_valid,
    // Enables and host DAC writes
    output logic             o_en_pin,
    output logic             o_soft_en,
    output logic             o_dac_wr,
    output logic [9:0]       o_bias,
    output logic [9:0]       o_mod
);
    // Idle at time zero
    initial begin
        {o_reg_wr, o_reg_rd, o_cmd_code, o_wr_data} = '0;
        {o_en_pin, o_soft_en, o_dac_wr, o_bias, o_mod} = '0;
    end
    // Register write; released data shows its inverse, never the stale word
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge i_sys_clk);
        o_reg_wr   <= 1'b1;
        o_cmd_code <= c;
        o_wr_data  <= d;
        @(posedge i_sys_clk);
        o_reg_wr  <= 1'b0;
        o_wr_data <= ~d;
    endtask : wr
    // Register read, bounded wait for the valid strobe
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        o_reg_rd   <= 1'b1;
        o_cmd_code <= c;
        @(posedge i_sys_clk);
        o_reg_rd <= 1'b0;
        #1;
        while (i_rd_valid !== 1'b1 && n < 8) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        d = i_rd_data;
    endtask : rd
    // Host stops or starts the transmitter by pin or soft enable
    task automatic en(input logic p, input logic s);
        @(posedge i_sys_clk);
        o_en_pin  <= p;
        o_soft_en <= s;
    endtask : en
    // DAC values go only over the host's own write path
    task automatic dac(input logic [9:0] v);
        @(posedge i_sys_clk);
        o_dac_wr <= 1'b1;
        o_bias   <= v;
        o_mod    <= ~v;
        @(posedge i_sys_clk);
        o_dac_wr <= 1'b0;
        o_bias   <= ~v;
    endtask : dac
endmodule : host_model

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the fault configuration logic.
// Assumes: Tick cut to 10 cycles, so the lockout window is about 250 cycles.
// Notes:   Detectors, servo and reset come from here; host side from host_model.
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] FC = fault_setup_pkg::FAULT_SETUP_CODE;
    logic        clk, rst_n, wr, rd, enp, sen, dwr, rv, p, lv;
    logic        ovp, unp, ovc, fix, tx, seed, flt, once, twice, pout, poe, p280, p425;
    logic [7:0]  code;
    logic [15:0] wd, rdd, d, v;
    logic [9:0]  sb, sm, hb, hm, bdac, mdac, s;
    int          n_mismatch = 0, cmp_count = 0, cyc = 0, n;
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    laser_fault_config_logic #(.TICK_CYCLES(10), .DAC_WIDTH(10)) laser_fault_config_logic_i (
        .i_sys_clk(clk), .i_reset_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_cmd_code(code),
        .i_wr_data(wd), .o_rd_data(rdd), .o_rd_valid(rv), .i_en_pin(enp), .i_soft_en(sen),
        .i_over_power(ovp), .i_under_power(unp), .i_over_current(ovc), .i_fixed_fault(fix),
        .i_servo_bias(sb), .i_servo_mod(sm), .i_host_bias_wr(dwr), .i_host_bias(hb),
        .i_host_mod_wr(dwr), .i_host_mod(hm), .o_tx_enabled(tx), .o_bias_current_dac(bdac),
        .o_modulation_current_dac(mdac), .o_servo_seed(seed), .o_faulted(flt),
        .o_faulted_once(once), .o_faulted_twice(twice), .o_fault_pin_out(pout),
        .o_fault_pin_oe(poe), .o_pullup_280_en(p280), .o_pullup_425_en(p425));
    host_model host_model_i (
        .i_sys_clk(clk), .o_reg_wr(wr), .o_reg_rd(rd), .o_cmd_code(code), .o_wr_data(wd),
        .i_rd_data(rdd), .i_rd_valid(rv), .o_en_pin(enp), .o_soft_en(sen), .o_dac_wr(dwr),
        .o_bias(hb), .o_mod(hm));
    // Hang guard, far above the several hundred cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    // Wire level expected at the fault pin: active shows the polarity bit
    function automatic logic exp_level(input logic pol, input logic ovr, input logic frc,
                                       input logic flt);
        return ~(pol ^ (ovr ? frc : flt));
    endfunction : exp_level
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    task automatic setf(input logic [15:0] x);
        host_model_i.wr(FC, x);
        step(2);
    endtask : setf
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    // Main sequence
    initial begin
        {ovp, unp, ovc, fix} = '0;
        rst_n = 1'b0;
        void'($urandom(32'h1C290D4F));
        sb = $urandom;
        sm = $urandom;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        step(1);
        host_model_i.rd(FC, d);
        check("setup reset", d, 16'h04E7);
        check("pin idle", poe ? pout : 1'b1, 1'b0);
        repeat (4) begin
            v = $urandom;
            host_model_i.wr(FC, v);
            host_model_i.rd(FC, d);
            check("setup rw", d, v & 16'h0FFF);
        end
        host_model_i.rd(8'h12, d);
        check("other code", d, 16'h0000);
        $display("test register done");
        // Each detector with its gate off and on, auto shutdown set
        for (int k = 0; k < 6; k++) begin
            host_model_i.en(1'b1, 1'b1);
            setf(16'h0040 | ((k / 3) << (k % 3)));
            check("tx on", tx, 1'b1);
            {ovp, unp, ovc} <= 3'h1 << (k % 3);
            step(3);
            check("gated", flt, k / 3);
            check("tx cut", tx, k < 3);
            {ovp, unp, ovc} <= 3'h0;
            host_model_i.en(1'b0, 1'b0);
            step(3);
        end
        host_model_i.en(1'b1, 1'b1);
        setf(16'h0001);
        ovc <= 1'b1;
        step(3);
        check("stay on", {flt, tx}, 2'h3);
        ovc <= 1'b0;
        host_model_i.en(1'b0, 1'b1);
        step(3);
        check("host off", tx, 1'b0);
        $display("test detect done");
        // Pin table: fault, force, override, drive mode; polarity random
        host_model_i.en(1'b0, 1'b0);
        for (int k = 0; k < 32; k++) begin
            p = $urandom;
            setf({6'h00, k[4:3], 2'h0, p, k[2:1], 3'h0});
            fix <= k[0];
            step(3);
            lv = exp_level(p, k[2], k[1], k[0]);
            check("pin level", poe ? pout : 1'b1, lv);
            check("pin drive", {p425, p280, poe | (k[4:3] != 2'h3), poe & pout & (k[4:3] != 2'h3)},
                  {k[4:3] == 2'h2, k[4:3] == 2'h1, 2'h2});
            check("latched", flt, k[0]);
        end
        fix <= 1'b0;
        $display("test pin done");
        // DAC ownership, then retention across a disable
        host_model_i.en(1'b1, 1'b1);
        setf(16'h0000);
        s = $urandom;
        host_model_i.dac(s);
        step(2);
        check("host dac", {bdac, mdac}, {s, ~s});
        setf(16'h0080);
        host_model_i.dac(~s);
        step(2);
        check("servo dac", {bdac, mdac}, {sb, sm});
        for (int f = 0; f < 2; f++) begin
            setf({5'h00, f[0], 10'h080});
            s = sb;
            host_model_i.en(1'b0, 1'b1);
            step(2);
            sb <= ~s;
            host_model_i.en(1'b1, 1'b1);
            n = 0;
            while (seed !== 1'b1 && n < 8) begin
                step(1);
                n++;
            end
            check("resume dac", bdac, f ? s : 10'h000);
        end
        $display("test dac done");
        // Lockout: second fault inside the window, then a quiet window
        for (int q = 0; q < 2; q++) begin
            rst_n <= 1'b0;
            step(2);
            rst_n <= 1'b1;
            host_model_i.en(1'b1, 1'b1);
            setf(16'h0841);
            ovc <= 1'b1;
            step(2);
            ovc <= 1'b0;
            host_model_i.en(1'b0, 1'b0);
            step(3);
            check("first flag", once, 1'b1);
            host_model_i.en(1'b1, 1'b1);
            step(3);
            check("retry on", tx, 1'b1);
            if (q == 0) begin
                ovc <= 1'b1;
                step(2);
                ovc <= 1'b0;
                host_model_i.en(1'b0, 1'b0);
                step(2);
                host_model_i.en(1'b1, 1'b1);
                step(3);
                check("locked", {twice, tx}, 2'h2);
            end else begin
                step(300);
                check("quiet", {once, tx}, 2'h1);
            end
        end
        $display("test lockout done");
        tally_and_finish();
    end
endmodule : tb_top
